//--- bench/procbus_properties.sv
`timescale 1ns/1ps
// ----------------------------------------
// arbitration and address tenure checks
// ----------------------------------------
module procbus_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic ctrl_bus_request_n,
  input wire logic ctrl_bus_grant_n,
  input wire logic cpu_bus_grant_n,
  input wire logic address_bus_busy_n,
  input wire logic transfer_start_n,
  input wire logic xfer_ack_n,
  input wire logic dev_abb_oe,
  input wire logic dev_ts_oe,
  input wire logic dev_addr_oe,
  input wire logic cpu_abb_oe,
  input wire logic cpu_ts_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // controller asks, is granted, and sees the bus free
  sequence qual_grant;
    !ctrl_bus_request_n && !ctrl_bus_grant_n && address_bus_busy_n;
  endsequence
  // busy held for the whole invalidate tenure, then let go
  sequence tenure;
    dev_abb_oe [*3] ##1 !dev_abb_oe;
  endsequence

  chk_one_grant: assert property (ctrl_bus_grant_n || cpu_bus_grant_n)
    else $error("two grants at once");
  chk_ctrl_first: assert property (!ctrl_bus_request_n |=> !ctrl_bus_grant_n)
    else $error("controller request not granted first");
  chk_req_hold: assert property ((!ctrl_bus_request_n && (ctrl_bus_grant_n || !address_bus_busy_n))
    |=> !ctrl_bus_request_n)
    else $error("request dropped early");
  chk_take_bus: assert property (qual_grant
    |=> ctrl_bus_request_n && dev_abb_oe && dev_ts_oe && dev_addr_oe)
    else $error("bus not taken on qualified grant");
  chk_no_early: assert property ($rose(dev_abb_oe)
    |-> !$past(ctrl_bus_grant_n) && $past(address_bus_busy_n))
    else $error("controller took bus unqualified");
  chk_cpu_qual: assert property ($rose(cpu_abb_oe)
    |-> !$past(cpu_bus_grant_n) && $past(address_bus_busy_n))
    else $error("processor took bus unqualified");
  chk_ts_single: assert property ($rose(dev_ts_oe) |=> !dev_ts_oe)
    else $error("start longer than one cycle");
  chk_busy_span: assert property ($rose(dev_abb_oe) |-> tenure)
    else $error("busy tenure wrong length");
  chk_ack_time: assert property ($fell(transfer_start_n) && cpu_ts_oe
    |-> ##2 !xfer_ack_n ##1 xfer_ack_n)
    else $error("acknowledge not two cycles after start");
  chk_cpu_release: assert property (!xfer_ack_n |=> !cpu_abb_oe)
    else $error("processor kept busy after ack");
endmodule

//--- bench/tb_processor_bus_request_attributes.sv
`timescale 1ns/1ps
// ----------------------------------------
// both bus ends face to face
// ----------------------------------------
module tb_processor_bus_request_attributes;
  typedef struct packed {
    procbus_pkg::attr_t a;
    logic [1:0] sz;
    logic al;
    logic bc;
    logic sb;
  } row_t;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, inv_addr, sc_addr, got_addr, adr;
  logic inv_req, inv_line, inv_busy, inv_done, onchip_mode;
  logic sc_write, sc_allocate, sc_write_through, sc_mark_invalid, sc_locked;
  logic sys_inv_broadcast, sys_burst, got_done;
  logic [1:0] sc_size;
  logic [7:0] got_vec;
  procbus_pkg::attr_t bus_attr;
  int err_total, checked, wr_cnt, k;
  row_t rows [6];

  procbus_if pb (.clk(clk));
  ctrl_end u_ctrl_end (.clk(clk), .rst(rst), .pb(pb), .inv_req(inv_req),
    .inv_addr(inv_addr), .inv_line(inv_line), .inv_busy(inv_busy), .inv_done(inv_done),
    .onchip_mode(onchip_mode), .sc_write(sc_write), .sc_addr(sc_addr), .sc_size(sc_size),
    .sc_allocate(sc_allocate), .sc_write_through(sc_write_through),
    .sc_mark_invalid(sc_mark_invalid), .sc_locked(sc_locked),
    .sys_inv_broadcast(sys_inv_broadcast), .sys_burst(sys_burst));
  host_end u_host_end (.clk(clk), .rst(rst), .pb(pb), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr));
  procbus_properties u_props (.clk(clk), .rst(rst),
    .ctrl_bus_request_n(pb.ctrl_bus_request_n), .ctrl_bus_grant_n(pb.ctrl_bus_grant_n),
    .cpu_bus_grant_n(pb.cpu_bus_grant_n), .address_bus_busy_n(pb.address_bus_busy_n),
    .transfer_start_n(pb.transfer_start_n), .xfer_ack_n(pb.xfer_ack_n),
    .dev_abb_oe(pb.dev_abb_oe), .dev_ts_oe(pb.dev_ts_oe), .dev_addr_oe(pb.dev_addr_oe),
    .cpu_abb_oe(pb.cpu_abb_oe), .cpu_ts_oe(pb.cpu_ts_oe));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // capture wire attributes at start and cache writes; negedge keeps it race free
  always @(negedge clk) begin
    if (!pb.transfer_start_n) bus_attr = pb.attr;
    if (sc_write) begin
      wr_cnt++;
      got_addr = sc_addr;
      got_done = inv_done;
      got_vec = {sc_size, sc_allocate, sys_inv_broadcast, sys_burst, sc_write_through,
        sc_locked, sc_mark_invalid};
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; waits for pready however long it takes
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (!pready);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_wr(input int n);
    k = 0;
    while (wr_cnt < n && k < 200) begin
      @(negedge clk);
      k++;
    end
    chk(wr_cnt, n);
  endtask

  // request stays up until the controller reports itself busy
  task automatic inv(input logic [31:0] a, input logic l);
    @(posedge clk);
    inv_addr <= a;
    inv_line <= l;
    inv_req <= 1'b1;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (!inv_busy && k < 50);
    @(posedge clk);
    inv_req <= 1'b0;
  endtask

  task automatic end_of_test;
    if (err_total == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // whole run needs well under two hundred cycles; reaching the 5000-cycle limit means a hang
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    end_of_test();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    inv_req = 1'b0;
    inv_addr = 32'h0000_0000;
    inv_line = 1'b0;
    rows[0] = '{16'hA001, 2'h0, 1'b0, 1'b0, 1'b0};
    rows[1] = '{16'h8B42, 2'h2, 1'b1, 1'b1, 1'b1};
    rows[2] = '{16'h4633, 2'h1, 1'b1, 1'b0, 1'b0};
    rows[3] = '{16'h1684, 2'h3, 1'b1, 1'b0, 1'b1};
    rows[4] = '{16'h0EC5, 2'h3, 1'b1, 1'b1, 1'b0};
    rows[5] = '{16'h9086, 2'h3, 1'b1, 1'b0, 1'b1};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk(onchip_mode, 1'b0);
    chk(pb.ctrl_bus_request_n, 1'b1);
    // processor transactions, one per row; invalidate set on writes and locked reads
    for (int i = 0; i < 6; i++) begin
      adr = 32'h0000_1000 + 32'(i) * 32'h0000_0040;
      apb(1'b1, 12'h004, adr);
      apb(1'b1, 12'h000, (32'(rows[i].a) << 8) | 32'h0000_0001);
      wait_wr(i + 1);
      chk(got_addr, adr);
      chk(got_done, 1'b0);
      chk(32'(bus_attr), 32'(rows[i].a));
      chk(got_vec, {rows[i].sz, rows[i].al, rows[i].bc, rows[i].sb,
        rows[i].a.write_through, rows[i].a.lock, 1'b0});
    end
    // done flag sets, then clears by writing one; done lands two edges after the ack
    repeat (2) @(posedge clk);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk(rd[5], 1'b1);
    apb(1'b1, 12'h008, 32'h0000_0020);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk(rd[5], 1'b0);
    // unmapped offset is refused
    apb(1'b1, 12'h0FC, 32'hFFFF_FFFF);
    chk(e, 1'b1);
    // controller invalidates on both primary lines
    for (int j = 0; j < 2; j++) begin
      inv(32'h0000_2000 + 32'(j) * 32'h0000_0020, j[0]);
      wait_wr(7 + j);
      chk(got_addr, 32'h0000_2000 + 32'(j) * 32'h0000_0020);
      chk({got_vec[7:6], got_vec[0]}, 3'b111);
      chk({bus_attr.rw, bus_attr.invalidate, bus_attr.global_data, bus_attr.cache_line},
        {3'b011, j[0]});
      chk(got_done, 1'b1);
    end
    // processor side saw the invalidate, last one on line one
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk(rd[4:3], 2'b11);
    // processor and controller ask for the bus back to back
    apb(1'b1, 12'h000, (32'(rows[3].a) << 8) | 32'h0000_0001);
    inv(32'h0000_3000, 1'b1);
    wait_wr(10);
    chk(pb.address_bus_busy_n, 1'b1);
    end_of_test();
  end
endmodule

//--- rtl/ctrl_end.sv
`timescale 1ns/1ps
`include "procbus_regs.svh"

// Notes on behaviour
// - external mode: own arbiter off, handshake only
// - external arbiter grants at most one master
// - arbiter favours controller over processor
// - config low at reset selects external arbitration
// - hold request until granted and bus free
// - qualified grant is grant with busy negated
// - on qualified grant: drop request, busy, start
// - arbiter tolerates processor never taking bus
// - write-through asserted, else write-back
// - burst attribute asserted means burst transaction
// - cache-inhibit asserted means never cache address
// - controller asserts invalidate toward processor
// - processor flags writes, locked reads, allocates
// - invalidate attribute may trigger system broadcast
// - all transactions write cache; invalidates tagged invalid
// - cache line attribute selects line one/zero
// - ignore size attribute during burst
// - lock marks one of atomic pair
// - global attribute marks data coherent
// - single-beat may become system burst
// - every cacheable processor transaction fills secondary cache
// - master drops busy when transaction completes
// - config high at reset selects on-chip arbitration
module ctrl_end (
  input wire logic clk,
  input wire logic rst,
  procbus_if.dev pb,
  input wire logic inv_req,
  input wire logic [31:0] inv_addr,
  input wire logic inv_line,
  output logic inv_busy,
  output logic inv_done,
  output logic onchip_mode,
  output logic sc_write,
  output logic [31:0] sc_addr,
  output logic [1:0] sc_size,
  output logic sc_allocate,
  output logic sc_write_through,
  output logic sc_mark_invalid,
  output logic sc_locked,
  output logic sys_inv_broadcast,
  output logic sys_burst
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // size is meaningless for bursts, which always move whole lines
  function automatic logic [1:0] eff_size(input procbus_pkg::attr_t a);
    eff_size = a.burst ? `SIZE_DOUBLE : a.size;
  endfunction

  // qualified grant: grant low and busy line seen negated
  function automatic logic qualified(input logic grant_n, input logic busy_n);
    qualified = !grant_n && busy_n;
  endfunction

  localparam logic [3:0] HOLD_LAST = 4'(`INV_HOLD_CYCLES - 1);

  procbus_pkg::master_state_t mstate;
  procbus_pkg::slave_state_t sstate;
  logic [3:0] hold_cnt;
  logic own_grant;
  procbus_pkg::attr_t cap_attr;
  logic [31:0] cap_addr;
  logic [31:0] pend_addr;
  logic pend_line;

  // ----------------------------------------
  // arbitration mode strap
  // ----------------------------------------
  // caught by a clocked process while reset is held, so the flop never
  // takes a port value asynchronously
  always_ff @(posedge clk) begin
    if (rst) begin
      onchip_mode <= pb.arbitration_enable_cfg;
    end
  end

  // in on-chip mode the grant is our own decision; in external mode it
  // comes only from the outside arbiter
  always_comb begin
    if (onchip_mode) begin
      own_grant = pb.address_bus_busy_n;
    end else begin
      own_grant = qualified(pb.ctrl_bus_grant_n, pb.address_bus_busy_n);
    end
  end

  // ----------------------------------------
  // master side: primary cache invalidate tenure
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      mstate <= procbus_pkg::M_IDLE;
      hold_cnt <= 4'h0;
      pend_addr <= `ADDR_RESET;
      pend_line <= 1'b0;
    end else begin
      case (mstate)
        procbus_pkg::M_IDLE: begin
          if (inv_req) begin
            pend_addr <= inv_addr;
            pend_line <= inv_line;
            mstate <= procbus_pkg::M_REQUEST;
          end
        end
        procbus_pkg::M_REQUEST: begin
          // stay here, requesting, until granted and the bus is free
          if (own_grant) begin
            mstate <= procbus_pkg::M_START;
          end
        end
        procbus_pkg::M_START: begin
          hold_cnt <= 4'h0;
          mstate <= procbus_pkg::M_HOLD;
        end
        procbus_pkg::M_HOLD: begin
          if (hold_cnt == HOLD_LAST) begin
            mstate <= procbus_pkg::M_RELEASE;
          end else begin
            hold_cnt <= hold_cnt + 4'h1;
          end
        end
        procbus_pkg::M_RELEASE: begin
          mstate <= procbus_pkg::M_IDLE;
        end
        default: begin
          mstate <= procbus_pkg::M_IDLE;
        end
      endcase
    end
  end

  // request pin: asserted only in external mode, dropped on the grant
  always_ff @(posedge clk) begin
    if (rst) begin
      pb.ctrl_bus_request_n <= 1'b1;
    end else if (onchip_mode) begin
      pb.ctrl_bus_request_n <= 1'b1;
    end else if (mstate == procbus_pkg::M_REQUEST && own_grant) begin
      pb.ctrl_bus_request_n <= 1'b1;
    end else if (mstate == procbus_pkg::M_REQUEST || (mstate == procbus_pkg::M_IDLE && inv_req)) begin
      pb.ctrl_bus_request_n <= 1'b0;
    end else begin
      pb.ctrl_bus_request_n <= 1'b1;
    end
  end

  // busy, start, address and attributes all go out on the grant edge;
  // busy stays low through the hold and is released once the tenure ends
  always_ff @(posedge clk) begin
    if (rst) begin
      pb.dev_abb_oe <= 1'b0;
      pb.dev_ts_oe <= 1'b0;
      pb.dev_addr_oe <= 1'b0;
    end else begin
      if (mstate == procbus_pkg::M_REQUEST && own_grant) begin
        pb.dev_abb_oe <= 1'b1;
        pb.dev_ts_oe <= 1'b1;
        pb.dev_addr_oe <= 1'b1;
      end else if (mstate == procbus_pkg::M_HOLD && hold_cnt == HOLD_LAST) begin
        pb.dev_abb_oe <= 1'b0;
        pb.dev_addr_oe <= 1'b0;
        pb.dev_ts_oe <= 1'b0;
      end else if (mstate == procbus_pkg::M_START) begin
        pb.dev_ts_oe <= 1'b0; // start lasts one clock
      end
    end
  end

  // open-drain levels: only the enable moves
  always_ff @(posedge clk) begin
    if (rst) begin
      pb.dev_abb_out <= 1'b1;
      pb.dev_ts_out <= 1'b1;
    end else begin
      pb.dev_abb_out <= 1'b0;
      pb.dev_ts_out <= 1'b0;
    end
  end

  // invalidate tenure attributes: write, invalidate, global, chosen line
  always_ff @(posedge clk) begin
    if (rst) begin
      pb.dev_addr <= `ADDR_RESET;
      pb.dev_attr <= '0;
    end else if (mstate == procbus_pkg::M_REQUEST && own_grant) begin
      pb.dev_addr <= pend_addr;
      pb.dev_attr <= '0;
      pb.dev_attr.rw <= 1'b0;
      pb.dev_attr.invalidate <= 1'b1;
      pb.dev_attr.global_data <= 1'b1;
      pb.dev_attr.cache_line <= pend_line;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      inv_busy <= 1'b0;
      inv_done <= 1'b0;
    end else begin
      inv_busy <= (mstate != procbus_pkg::M_IDLE) || inv_req;
      inv_done <= (mstate == procbus_pkg::M_RELEASE);
    end
  end

  // ----------------------------------------
  // slave side: processor transactions
  // ----------------------------------------
  // one wait state for the tag lookup, then acknowledge
  always_ff @(posedge clk) begin
    if (rst) begin
      sstate <= procbus_pkg::S_IDLE;
      cap_attr <= '0;
      cap_addr <= `ADDR_RESET;
    end else begin
      case (sstate)
        procbus_pkg::S_IDLE: begin
          if (!pb.transfer_start_n && pb.cpu_ts_oe) begin
            cap_attr <= pb.attr;
            cap_addr <= pb.addr;
            sstate <= procbus_pkg::S_WAIT;
          end
        end
        procbus_pkg::S_WAIT: begin
          sstate <= procbus_pkg::S_ACK;
        end
        procbus_pkg::S_ACK: begin
          sstate <= procbus_pkg::S_IDLE;
        end
        default: begin
          sstate <= procbus_pkg::S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pb.xfer_ack_n <= 1'b1;
    end else begin
      pb.xfer_ack_n <= !(sstate == procbus_pkg::S_WAIT);
    end
  end

  // secondary cache and system side effects, one-cycle pulses.
  // our own invalidate tenure also writes the array but tags it invalid.
  always_ff @(posedge clk) begin
    if (rst) begin
      sc_write <= 1'b0;
      sc_addr <= `ADDR_RESET;
      sc_size <= `SIZE_BYTE;
      sc_allocate <= 1'b0;
      sc_write_through <= 1'b0;
      sc_mark_invalid <= 1'b0;
      sc_locked <= 1'b0;
      sys_inv_broadcast <= 1'b0;
      sys_burst <= 1'b0;
    end else if (sstate == procbus_pkg::S_WAIT) begin
      sc_write <= 1'b1;
      sc_addr <= cap_addr;
      sc_size <= eff_size(cap_attr);
      sc_allocate <= !cap_attr.cache_inhibit;
      sc_write_through <= cap_attr.write_through;
      sc_mark_invalid <= 1'b0;
      sc_locked <= cap_attr.lock;
      // a broadcast is needed only for coherent data
      sys_inv_broadcast <= cap_attr.invalidate && cap_attr.global_data;
      // cacheable single-beat reads fetch the whole line on the system bus
      sys_burst <= cap_attr.burst || (cap_attr.rw && !cap_attr.cache_inhibit);
    end else if (mstate == procbus_pkg::M_RELEASE) begin
      sc_write <= 1'b1;
      sc_addr <= pend_addr;
      sc_size <= `SIZE_DOUBLE;
      sc_allocate <= 1'b1;
      sc_write_through <= 1'b0;
      sc_mark_invalid <= 1'b1;
      sc_locked <= 1'b0;
      sys_inv_broadcast <= 1'b0;
      sys_burst <= 1'b0;
    end else begin
      sc_write <= 1'b0;
      sc_mark_invalid <= 1'b0;
      sys_inv_broadcast <= 1'b0;
      sys_burst <= 1'b0;
    end
  end

endmodule

//--- rtl/host_end.sv
`timescale 1ns/1ps
`include "procbus_regs.svh"

// external arbiter plus processor agent, commanded over APB
module host_end (
  input wire logic clk,
  input wire logic rst,
  procbus_if.host pb,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr
);

  procbus_pkg::master_state_t mstate;
  logic [31:0] cmd_addr;
  procbus_pkg::attr_t cmd_attr;
  logic inv_seen;
  logic inv_line;
  logic done;
  logic go;
  logic cancel;
  logic wr_status;
  logic own_grant;
  logic snoop_inv;

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // no wait states: pready rises in the first access cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      if (psel && !penable) begin
        pslverr <= !(paddr == `REG_CMD || paddr == `REG_ADDR || paddr == `REG_STATUS);
        case (paddr)
          `REG_ADDR: prdata <= cmd_addr;
          `REG_CMD: prdata <= 32'({cmd_attr, 8'h00});
          `REG_STATUS: prdata <= 32'({done, inv_line, inv_seen, !pb.cpu_bus_grant_n,
                                      !pb.ctrl_bus_grant_n, mstate != procbus_pkg::M_IDLE});
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign go = psel && penable && pready && pwrite && paddr == `REG_CMD && pwdata[`CMD_GO_BIT];
  assign cancel = psel && penable && pready && pwrite && paddr == `REG_CMD
                  && pwdata[`CMD_CANCEL_BIT];
  assign wr_status = psel && penable && pready && pwrite && paddr == `REG_STATUS;

  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_addr <= `ADDR_RESET;
      cmd_attr <= '0;
    end else if (psel && penable && pready && pwrite && paddr == `REG_ADDR) begin
      cmd_addr <= pwdata;
    end else if (psel && penable && pready && pwrite && paddr == `REG_CMD
                 && mstate == procbus_pkg::M_IDLE) begin
      cmd_attr <= pwdata[`CMD_ATTR_MSB:`CMD_ATTR_LSB];
    end
  end

  // ----------------------------------------
  // external arbiter
  // ----------------------------------------
  // at most one grant; controller first, otherwise processor stays parked.
  // re-decided every clock, so a processor that never takes the bus
  // after a grant stalls nobody
  always_ff @(posedge clk) begin
    if (rst) begin
      pb.ctrl_bus_grant_n <= 1'b1;
      pb.cpu_bus_grant_n <= 1'b1;
      pb.arbitration_enable_cfg <= 1'b0;
    end else begin
      pb.ctrl_bus_grant_n <= pb.ctrl_bus_request_n;
      pb.cpu_bus_grant_n <= !pb.ctrl_bus_request_n;
      pb.arbitration_enable_cfg <= 1'b0;
    end
  end

  assign own_grant = !pb.cpu_bus_grant_n && pb.address_bus_busy_n;

  // ----------------------------------------
  // processor agent
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      mstate <= procbus_pkg::M_IDLE;
    end else begin
      case (mstate)
        procbus_pkg::M_IDLE: begin
          if (go) begin
            mstate <= procbus_pkg::M_REQUEST;
          end
        end
        procbus_pkg::M_REQUEST: begin
          if (cancel) begin
            mstate <= procbus_pkg::M_IDLE;
          end else if (own_grant) begin
            mstate <= procbus_pkg::M_START;
          end
        end
        procbus_pkg::M_START: begin
          mstate <= procbus_pkg::M_HOLD;
        end
        procbus_pkg::M_HOLD: begin
          if (!pb.xfer_ack_n) begin
            mstate <= procbus_pkg::M_RELEASE;
          end
        end
        procbus_pkg::M_RELEASE: begin
          mstate <= procbus_pkg::M_IDLE;
        end
        default: begin
          mstate <= procbus_pkg::M_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pb.cpu_bus_request_n <= 1'b1;
      pb.cpu_abb_oe <= 1'b0;
      pb.cpu_ts_oe <= 1'b0;
      pb.cpu_addr_oe <= 1'b0;
      pb.cpu_abb_out <= 1'b1;
      pb.cpu_ts_out <= 1'b1;
      pb.cpu_addr <= `ADDR_RESET;
      pb.cpu_attr <= '0;
    end else begin
      pb.cpu_abb_out <= 1'b0;
      pb.cpu_ts_out <= 1'b0;
      // a parked processor needs no request
      pb.cpu_bus_request_n <= !(mstate == procbus_pkg::M_REQUEST && !own_grant && !cancel);
      if (mstate == procbus_pkg::M_REQUEST && own_grant && !cancel) begin
        pb.cpu_abb_oe <= 1'b1;
        pb.cpu_ts_oe <= 1'b1;
        pb.cpu_addr_oe <= 1'b1;
        pb.cpu_addr <= cmd_addr;
        pb.cpu_attr <= cmd_attr;
      end else if (mstate == procbus_pkg::M_START) begin
        pb.cpu_ts_oe <= 1'b0;
      end else if (mstate == procbus_pkg::M_HOLD && !pb.xfer_ack_n) begin
        pb.cpu_abb_oe <= 1'b0;
        pb.cpu_addr_oe <= 1'b0;
      end
    end
  end

  // sticky status; a new event wins over a software clear
  assign snoop_inv = !pb.transfer_start_n && pb.dev_ts_oe && pb.attr.invalidate;

  always_ff @(posedge clk) begin
    if (rst) begin
      inv_seen <= 1'b0;
      inv_line <= 1'b0;
      done <= 1'b0;
    end else begin
      if (snoop_inv) begin
        inv_seen <= 1'b1;
        inv_line <= pb.attr.cache_line;
      end else if (wr_status && pwdata[`STAT_INV_SEEN_BIT]) begin
        inv_seen <= 1'b0;
      end
      if (mstate == procbus_pkg::M_RELEASE) begin
        done <= 1'b1;
      end else if (go || (wr_status && pwdata[`STAT_DONE_BIT])) begin
        done <= 1'b0;
      end
    end
  end

endmodule

//--- shared/procbus_if.sv
`timescale 1ns/1ps
interface procbus_if (
  input wire logic clk
);
  // arbitration
  logic ctrl_bus_request_n;
  logic ctrl_bus_grant_n;
  logic cpu_bus_request_n;
  logic cpu_bus_grant_n;
  logic arbitration_enable_cfg;
  logic xfer_ack_n;
  // shared open-drain and three-state lines, one driver set per party
  logic dev_abb_out;
  logic dev_abb_oe;
  logic cpu_abb_out;
  logic cpu_abb_oe;
  logic dev_ts_out;
  logic dev_ts_oe;
  logic cpu_ts_out;
  logic cpu_ts_oe;
  logic [31:0] dev_addr;
  logic dev_addr_oe;
  logic [31:0] cpu_addr;
  logic cpu_addr_oe;
  procbus_pkg::attr_t dev_attr;
  procbus_pkg::attr_t cpu_attr;
  // resolved wire levels
  logic address_bus_busy_n;
  logic transfer_start_n;
  logic [31:0] addr;
  procbus_pkg::attr_t attr;

  // wired-and: any enabled low driver pulls the line down
  assign address_bus_busy_n = !((dev_abb_oe && !dev_abb_out) || (cpu_abb_oe && !cpu_abb_out));
  assign transfer_start_n = !((dev_ts_oe && !dev_ts_out) || (cpu_ts_oe && !cpu_ts_out));
  assign addr = dev_addr_oe ? dev_addr : (cpu_addr_oe ? cpu_addr : 32'h0000_0000);
  assign attr = dev_addr_oe ? dev_attr : cpu_attr;

  modport dev (
    input clk, ctrl_bus_grant_n, arbitration_enable_cfg, address_bus_busy_n,
    input transfer_start_n, addr, attr, cpu_ts_oe,
    output ctrl_bus_request_n, xfer_ack_n, dev_abb_out, dev_abb_oe,
    output dev_ts_out, dev_ts_oe, dev_addr, dev_addr_oe, dev_attr
  );

  modport host (
    input clk, ctrl_bus_request_n, xfer_ack_n, address_bus_busy_n,
    input transfer_start_n, addr, attr, dev_ts_oe,
    output ctrl_bus_grant_n, cpu_bus_request_n, cpu_bus_grant_n, arbitration_enable_cfg,
    output cpu_abb_out, cpu_abb_oe, cpu_ts_out, cpu_ts_oe, cpu_addr, cpu_addr_oe, cpu_attr
  );
endinterface

//--- shared/procbus_pkg.sv
package procbus_pkg;

  // transfer attributes carried with every address tenure
  typedef struct packed {
    logic rw;              // 1 read, 0 write
    logic write_through;   // 1 write-through, 0 write-back
    logic cache_inhibit;   // 1 not cacheable anywhere
    logic burst;           // 1 burst, 0 single-beat
    logic [1:0] size;      // meaningful only for single-beat
    logic invalidate;
    logic lock;            // one of an atomic pair
    logic cache_line;      // primary line 1 or 0
    logic global_data;     // 1 coherent, 0 local
    logic [1:0] user_page;
    logic [3:0] transfer_code;
  } attr_t;

  typedef enum logic [2:0] {
    M_IDLE, M_REQUEST, M_START, M_HOLD, M_RELEASE
  } master_state_t;

  typedef enum logic [1:0] {
    S_IDLE, S_WAIT, S_ACK
  } slave_state_t;

endpackage

//--- shared/procbus_regs.svh
`ifndef PROCBUS_REGS_SVH
`define PROCBUS_REGS_SVH

// ----------------------------------------
// transfer size codes
// ----------------------------------------
`define SIZE_BYTE 2'h0
`define SIZE_HALF 2'h1
`define SIZE_WORD 2'h2
`define SIZE_DOUBLE 2'h3

// ----------------------------------------
// controller own transaction timing
// ----------------------------------------
`define INV_HOLD_NS 20
`define CLK_PERIOD_NS 10
`define INV_HOLD_CYCLES ((`INV_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------
// host register map (byte offsets)
// ----------------------------------------
`define REG_CMD 12'h000
`define REG_ADDR 12'h004
`define REG_STATUS 12'h008

// ----------------------------------------
// command register fields
// ----------------------------------------
`define CMD_GO_BIT 0
`define CMD_CANCEL_BIT 1
`define CMD_ATTR_LSB 8
`define CMD_ATTR_MSB 23

// ----------------------------------------
// status register fields
// ----------------------------------------
`define STAT_BUSY_BIT 0
`define STAT_CTRL_GRANT_BIT 1
`define STAT_PARKED_BIT 2
`define STAT_INV_SEEN_BIT 3
`define STAT_INV_LINE_BIT 4
`define STAT_DONE_BIT 5

`define ADDR_RESET 32'h0000_0000

`endif
